// [hw/strap_pkg.sv]
// Shared constants and types for the strap latch and test mode decode block
package strap_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] STRAP_CONFIG_STATUS_OFFSET = 12'h4C0;
  localparam logic [11:0] TEST_STATUS_OFFSET = 12'h4C4;
  localparam logic [11:0] PAD_CONTROL_OFFSET = 12'h4C8;

  // ----------------------------------------------------------------
  // Strap field layout
  // ----------------------------------------------------------------
  localparam int STRAP_W = 8;
  localparam int HOST_SELECT_BIT = 7;
  localparam int RESERVED_HI_BIT = 6;
  localparam int RESERVED_LO_BIT = 5;
  localparam int ROM_SIZE_BIT = 4;
  localparam int USER_DEFINED_MSB = 3;
  localparam int USER_DEFINED_LSB = 0;
  // Pins 15..12 read inverted, pins 11..8 read as they stand
  localparam logic [7:0] STRAP_INVERT_MASK = 8'hF0;
  localparam logic [7:0] STRAP_RESET_VALUE = 8'h00;

  // ----------------------------------------------------------------
  // Test status and pad control fields
  // ----------------------------------------------------------------
  localparam int TSTAT_MODE_LSB = 0;
  localparam int TSTAT_CAPTURED_BIT = 2;
  localparam int TSTAT_HIZ_BIT = 3;
  localparam int TSTAT_PINS_LSB = 8;
  localparam int PCTRL_RELEASE_BIT = 0;
  localparam logic PCTRL_RELEASE_RESET = 1'h0;

  // ----------------------------------------------------------------
  // Test select codes and modes
  // ----------------------------------------------------------------
  localparam logic [3:0] SELECT_CONNECTIVITY = 4'hE;
  localparam logic [3:0] SELECT_TRISTATE = 4'hF;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_CONNECTIVITY = 2'b01,
    MODE_TRISTATE = 2'b10,
    MODE_RESERVED = 2'b11
  } test_mode_type;

endpackage : strap_pkg

// [hw/sync2.sv]
// Two flip-flop level synchroniser for pin inputs
module sync2 #(
  parameter int W = 1
) (
  input wire logic pclk, // Destination clock
  input wire logic [W-1:0] d, // Asynchronous levels
  output logic [W-1:0] q // Synchronised levels
);

  // No reset, so the chain tracks the pins while reset is held
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_type;

  sync_state_type s_q;
  sync_state_type s_d;

  always_comb begin
    s_d.meta = d;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge pclk) begin
    s_q <= s_d;
  end

  assign q = s_q.stable;

endmodule : sync2

// [hw/nand_tree.sv]
// Connectivity test array: one NAND gate per group of input pins
module nand_tree #(
  parameter int GROUPS = 8,
  parameter int GROUP_W = 4
) (
  input wire logic [GROUPS*GROUP_W-1:0] pins_in, // Levels of the tested input pins
  output logic [GROUPS-1:0] gate_out // Low only while every pin of its group is high
);

  genvar g;
  generate
    for (g = 0; g < GROUPS; g++) begin : g_gate
      assign gate_out[g] = ~&pins_in[g*GROUP_W +: GROUP_W];
    end
  endgenerate

endmodule : nand_tree

// [hw/strap_latch_and_test_mode_decode.sv]
// Power-on strap capture, strap register over APB and board test mode decode
module strap_latch_and_test_mode_decode #(
  parameter int TEST_GROUPS = 8,
  parameter int TEST_GROUP_W = 4
) (
  input wire logic pclk, // APB clock, 100 MHz
  input wire logic presetn, // System reset, asynchronous, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic pready, // APB ready
  output logic [31:0] prdata, // APB read data
  output logic pslverr, // APB error, unmapped address
  input wire logic [7:0] rom_addr_strap_in, // Pad levels of ROM address 15..8
  input wire logic [7:0] rom_addr_core, // ROM address 15..8 from the ROM port
  output logic [7:0] rom_addr_strap_out, // Pad drive of ROM address 15..8
  output logic [7:0] rom_addr_strap_oe_n, // Pad enable, low drives
  input wire logic test_enable_n, // Test enable pin, active low
  input wire logic [3:0] panel_data_in, // Pad levels of panel data 28..25
  input wire logic [3:0] panel_data_core, // Panel data 28..25 from the panel path
  output logic [3:0] panel_data_out, // Pad drive of panel data 28..25
  output logic [3:0] panel_data_oe_n, // Pad enable, low drives
  input wire logic [TEST_GROUPS*TEST_GROUP_W-1:0] iotest_in, // Pins tested as array inputs
  output logic [TEST_GROUPS-1:0] iotest_out, // Array outputs
  output logic [TEST_GROUPS-1:0] iotest_oe_n, // Array output enable, low drives
  output logic connectivity_mode, // Connectivity test active
  output logic all_outputs_hiz // Every chip driver must float
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic captured;
    logic [7:0] strap;
    logic release_pads;
    logic ready;
    logic slverr;
    logic [31:0] rdata;
    logic [7:0] rom_out;
    logic [7:0] rom_oe_n;
    logic [3:0] panel_out;
    logic [3:0] panel_oe_n;
    logic [TEST_GROUPS-1:0] test_out;
    logic [TEST_GROUPS-1:0] test_oe_n;
    logic conn;
    logic hiz;
  } state_type;

  localparam state_type STATE_RESET = '{
    captured: 1'h0,
    strap: strap_pkg::STRAP_RESET_VALUE,
    release_pads: strap_pkg::PCTRL_RELEASE_RESET,
    ready: 1'h0,
    slverr: 1'h0,
    rdata: 32'h00000000,
    rom_out: 8'h00,
    rom_oe_n: 8'hFF,
    panel_out: 4'h0,
    panel_oe_n: 4'hF,
    test_out: '0,
    test_oe_n: '1,
    conn: 1'h0,
    hiz: 1'h0
  };

  state_type s_q;
  state_type s_d;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] strap_pins_s;
  logic test_n_s;
  logic [3:0] select_s;
  logic [TEST_GROUPS*TEST_GROUP_W-1:0] iotest_s;
  logic [TEST_GROUPS-1:0] tree_out;
  strap_pkg::test_mode_type mode;
  logic access;
  logic hit_strap;
  logic hit_tstat;
  logic hit_pctrl;

  sync2 #(.W(8)) u_sync_strap (
    .pclk(pclk),
    .d(rom_addr_strap_in),
    .q(strap_pins_s)
  );

  sync2 #(.W(5)) u_sync_test (
    .pclk(pclk),
    .d({test_enable_n, panel_data_in}),
    .q({test_n_s, select_s})
  );

  sync2 #(.W(TEST_GROUPS*TEST_GROUP_W)) u_sync_iotest (
    .pclk(pclk),
    .d(iotest_in),
    .q(iotest_s)
  );

  nand_tree #(.GROUPS(TEST_GROUPS), .GROUP_W(TEST_GROUP_W)) u_tree (
    .pins_in(iotest_s),
    .gate_out(tree_out)
  );

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic strap_pkg::test_mode_type decode_mode(input logic test_n, input logic [3:0] sel);
    if (test_n) begin
      decode_mode = strap_pkg::MODE_NORMAL;
    end else if (sel == strap_pkg::SELECT_CONNECTIVITY) begin
      decode_mode = strap_pkg::MODE_CONNECTIVITY;
    end else if (sel == strap_pkg::SELECT_TRISTATE) begin
      decode_mode = strap_pkg::MODE_TRISTATE;
    end else begin
      decode_mode = strap_pkg::MODE_RESERVED;
    end
  endfunction : decode_mode

  function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] offset);
    addr_is = (addr == offset);
  endfunction : addr_is

  // No latch: the mode is recomputed from the pins every cycle
  assign mode = decode_mode(test_n_s, select_s);
  assign access = psel && penable && !s_q.ready;
  assign hit_strap = addr_is(paddr, strap_pkg::STRAP_CONFIG_STATUS_OFFSET);
  assign hit_tstat = addr_is(paddr, strap_pkg::TEST_STATUS_OFFSET);
  assign hit_pctrl = addr_is(paddr, strap_pkg::PAD_CONTROL_OFFSET);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;

    // Capture once, on the first edge after release; the pins were
    // released during reset, so the synchroniser already holds them
    if (!s_q.captured) begin
      s_d.captured = 1'h1;
      s_d.strap = strap_pins_s ^ strap_pkg::STRAP_INVERT_MASK;
    end

    // APB: one wait state, answer lands with pready
    s_d.ready = access;
    s_d.slverr = 1'h0;
    if (access) begin
      s_d.rdata = 32'h00000000;
      if (hit_strap) begin
        s_d.rdata[7:0] = s_q.strap;
      end else if (hit_tstat) begin
        s_d.rdata[strap_pkg::TSTAT_MODE_LSB +: 2] = mode;
        s_d.rdata[strap_pkg::TSTAT_CAPTURED_BIT] = s_q.captured;
        s_d.rdata[strap_pkg::TSTAT_HIZ_BIT] = s_q.hiz;
        s_d.rdata[strap_pkg::TSTAT_PINS_LSB +: 8] = strap_pins_s;
      end else if (hit_pctrl) begin
        s_d.rdata[strap_pkg::PCTRL_RELEASE_BIT] = s_q.release_pads;
      end else begin
        s_d.slverr = 1'h1;
      end
    end
    // Writes to the strap register are dropped without error
    if (psel && penable && s_q.ready && pwrite && hit_pctrl) begin
      s_d.release_pads = pwdata[strap_pkg::PCTRL_RELEASE_BIT];
    end

    // Pads
    s_d.conn = (mode == strap_pkg::MODE_CONNECTIVITY);
    s_d.hiz = (mode == strap_pkg::MODE_TRISTATE);
    s_d.rom_out = rom_addr_core;
    // Held released until the straps are in
    if (!s_q.captured || s_q.release_pads || s_d.hiz) begin
      s_d.rom_oe_n = 8'hFF;
    end else begin
      s_d.rom_oe_n = 8'h00;
    end
    s_d.panel_out = panel_data_core;
    // Select pins turn to inputs as soon as test enable is seen low
    s_d.panel_oe_n = test_n_s ? 4'h0 : 4'hF;
    s_d.test_out = tree_out;
    s_d.test_oe_n = s_d.conn ? '0 : '1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pready = s_q.ready;
  assign prdata = s_q.rdata;
  assign pslverr = s_q.slverr;
  assign rom_addr_strap_out = s_q.rom_out;
  assign rom_addr_strap_oe_n = s_q.rom_oe_n;
  assign panel_data_out = s_q.panel_out;
  assign panel_data_oe_n = s_q.panel_oe_n;
  assign iotest_out = s_q.test_out;
  assign iotest_oe_n = s_q.test_oe_n;
  assign connectivity_mode = s_q.conn;
  assign all_outputs_hiz = s_q.hiz;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_released_until_capture;
    !s_q.captured |-> (rom_addr_strap_oe_n == 8'hFF);
  endproperty
  a_released_until_capture: assert property (p_released_until_capture)
    else $error("strap pins driven before capture");

  property p_capture_value;
    $rose(s_q.captured) |-> (s_q.strap == ($past(strap_pins_s) ^ strap_pkg::STRAP_INVERT_MASK));
  endproperty
  a_capture_value: assert property (p_capture_value)
    else $error("strap register does not match captured pins");

  property p_strap_frozen;
    s_q.captured && $past(s_q.captured) |-> $stable(s_q.strap);
  endproperty
  a_strap_frozen: assert property (p_strap_frozen)
    else $error("strap register changed after capture");

  property p_strap_read;
    access && !pwrite && hit_strap |=> pready && !pslverr && (prdata == {24'h000000, s_q.strap});
  endproperty
  a_strap_read: assert property (p_strap_read)
    else $error("strap register read returned wrong data");

  property p_host_bit;
    $rose(s_q.captured) |-> (s_q.strap[strap_pkg::HOST_SELECT_BIT] == !$past(strap_pins_s[7]));
  endproperty
  a_host_bit: assert property (p_host_bit)
    else $error("host select bit not inverted pin 15");

  property p_rom_size_bit;
    $rose(s_q.captured) |-> (s_q.strap[strap_pkg::ROM_SIZE_BIT] == !$past(strap_pins_s[4]));
  endproperty
  a_rom_size_bit: assert property (p_rom_size_bit)
    else $error("rom size bit not inverted pin 12");

  property p_user_bits;
    $rose(s_q.captured) |-> (s_q.strap[3:0] == $past(strap_pins_s[3:0]));
  endproperty
  a_user_bits: assert property (p_user_bits)
    else $error("user bits differ from pins 8 to 11");

  property p_reserved_bits;
    $rose(s_q.captured) && $past(strap_pins_s[6:5]) == 2'h3 |-> (s_q.strap[6:5] == 2'h0);
  endproperty
  a_reserved_bits: assert property (p_reserved_bits)
    else $error("reserved bits nonzero at default pins");

  // Reset values still stand one edge after release, so the panel, connectivity and tristate entry checks wait for the capture
  property p_normal_panel;
    s_q.captured && test_n_s |=> (panel_data_oe_n == 4'h0) && (panel_data_out == $past(panel_data_core))
      && !all_outputs_hiz;
  endproperty
  a_normal_panel: assert property (p_normal_panel)
    else $error("panel pins disturbed in normal operation");

  property p_conn_entry;
    s_q.captured && !test_n_s && select_s == strap_pkg::SELECT_CONNECTIVITY
      |=> connectivity_mode && (iotest_oe_n == '0);
  endproperty
  a_conn_entry: assert property (p_conn_entry)
    else $error("connectivity mode not entered");

  property p_hiz_entry;
    s_q.captured && !test_n_s && select_s == strap_pkg::SELECT_TRISTATE
      |=> all_outputs_hiz && (rom_addr_strap_oe_n == 8'hFF)
      && (panel_data_oe_n == 4'hF) && (iotest_oe_n == '1);
  endproperty
  a_hiz_entry: assert property (p_hiz_entry)
    else $error("drivers not floated in tristate mode");

  property p_reserved_code;
    !test_n_s && select_s < strap_pkg::SELECT_CONNECTIVITY |=> !connectivity_mode && !all_outputs_hiz;
  endproperty
  a_reserved_code: assert property (p_reserved_code)
    else $error("reserved select code entered a test mode");

  property p_gate_low;
    mode == strap_pkg::MODE_CONNECTIVITY && (&iotest_s) |=> (iotest_out == '0);
  endproperty
  a_gate_low: assert property (p_gate_low)
    else $error("array output not low with all inputs high");

  property p_exit_test;
    !test_n_s ##1 test_n_s |=> !connectivity_mode && !all_outputs_hiz && (panel_data_oe_n == 4'h0);
  endproperty
  a_exit_test: assert property (p_exit_test)
    else $error("test mode held after test enable released");

  c_capture: cover property ($rose(s_q.captured));
  c_strap_read: cover property (access && !pwrite && hit_strap);
  c_conn: cover property ($rose(connectivity_mode));
  c_hiz: cover property ($rose(all_outputs_hiz));

endmodule : strap_latch_and_test_mode_decode

// [test/board_model.sv]
// Board model: strap resistors, pad pull-ups and test equipment
module board_model (
  input wire logic pclk, // Bench clock
  input wire logic [7:0] strap_pd, // Pull-down fitted per strap pin
  input wire logic test_on, // Equipment holds test enable low
  input wire logic [3:0] test_sel, // Select code from equipment
  input wire logic [31:0] iotest_drive, // Equipment levels on tested pins
  input wire logic [7:0] rom_out, // Chip drive of strap pins
  input wire logic [7:0] rom_oe_n, // Chip enable of strap pins
  input wire logic [3:0] panel_out, // Chip drive of select pins
  input wire logic [3:0] panel_oe_n, // Chip enable of select pins
  output logic [7:0] rom_lvl, // Strap pin levels
  output logic test_enable_n, // Test enable pin level
  output logic [3:0] panel_lvl, // Select pin levels
  output logic [31:0] iotest_lvl // Tested pin levels
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] last_q = 4'hF;
  // Released strap pins sit at the pull-up unless a pull-down is fitted
  assign rom_lvl = (~rom_oe_n & rom_out) | (rom_oe_n & ~strap_pd);
  assign test_enable_n = ~test_on;
  // Floating select pins toggle, so a stale level can never pass for a driven one
  assign panel_lvl = test_on ? test_sel : ((~panel_oe_n & panel_out) | (panel_oe_n & ~last_q));
  assign iotest_lvl = iotest_drive;
  always @(posedge pclk) last_q <= panel_lvl;
endmodule : board_model

// [test/testbench.sv]
// Self-checking bench for the strap latch and test mode decode block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, test_enable_n, connectivity_mode, all_outputs_hiz;
  logic [31:0] prdata, iotest_in, rd;
  logic [7:0] rom_addr_strap_in, rom_addr_strap_out, rom_addr_strap_oe_n, iotest_out, iotest_oe_n;
  logic [7:0] rom_addr_core = 8'h00;
  logic [3:0] panel_data_core = 4'h0;
  logic [3:0] panel_data_in, panel_data_out, panel_data_oe_n;
  logic [7:0] strap_pd = 8'h00;
  logic test_on = 1'b0;
  logic [3:0] test_sel = 4'h0;
  logic [31:0] iotest_drive = 32'hFFFFFFFF;
  logic err;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;

  always #5 pclk = ~pclk;

  strap_latch_and_test_mode_decode strap_latch_and_test_mode_decode_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .rom_addr_strap_in(rom_addr_strap_in), .rom_addr_core(rom_addr_core),
    .rom_addr_strap_out(rom_addr_strap_out), .rom_addr_strap_oe_n(rom_addr_strap_oe_n),
    .test_enable_n(test_enable_n), .panel_data_in(panel_data_in), .panel_data_core(panel_data_core),
    .panel_data_out(panel_data_out), .panel_data_oe_n(panel_data_oe_n), .iotest_in(iotest_in),
    .iotest_out(iotest_out), .iotest_oe_n(iotest_oe_n), .connectivity_mode(connectivity_mode),
    .all_outputs_hiz(all_outputs_hiz));

  board_model board_model_i (.pclk(pclk), .strap_pd(strap_pd), .test_on(test_on), .test_sel(test_sel),
    .iotest_drive(iotest_drive), .rom_out(rom_addr_strap_out), .rom_oe_n(rom_addr_strap_oe_n),
    .panel_out(panel_data_out), .panel_oe_n(panel_data_oe_n), .rom_lvl(rom_addr_strap_in),
    .test_enable_n(test_enable_n), .panel_lvl(panel_data_in), .iotest_lvl(iotest_in));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // A run still going at cycle 5000 ends here; the APB wait gives up by itself after 20 polls
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      stop_test();
    end
  end

  function automatic logic [31:0] strap_exp(input logic [7:0] pd);
    return {24'h0, pd[7:4], ~pd[3:0]};
  endfunction : strap_exp

  function automatic logic [7:0] nand_exp(input logic [31:0] v);
    for (int g = 0; g < 8; g++) begin
      nand_exp[g] = ~&v[4*g +: 4];
    end
  endfunction : nand_exp

  // One idle edge after each transfer keeps two drives of psel out of one time step
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) check("pready", 32'h0, 32'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic do_reset(input logic [7:0] pd);
    strap_pd <= pd;
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    check("strap oe_n in reset", {24'h0, rom_addr_strap_oe_n}, 32'hFF);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : do_reset

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] pd;
    logic [31:0] v;
    v = $urandom(32'h6901);
    for (int i = 0; i < 6; i++) begin
      // Reserved strap pins carry no pull-down through reset and capture
      pd = (i == 0) ? 8'h00 : (i == 1) ? 8'h9F : 8'($urandom) & 8'h9F;
      rom_addr_core <= 8'($urandom);
      do_reset(pd);
      apb(strap_pkg::STRAP_CONFIG_STATUS_OFFSET, 1'b0, 32'h0, rd, err);
      check("strap reg", rd, strap_exp(pd));
      check("strap err", {31'h0, err}, 32'h0);
      check("rom pads driven", {16'h0, rom_addr_strap_oe_n, rom_addr_strap_out}, {24'h0, rom_addr_core});
      apb(strap_pkg::STRAP_CONFIG_STATUS_OFFSET, 1'b1, $urandom, rd, err);
      apb(strap_pkg::PAD_CONTROL_OFFSET, 1'b1, 32'h1, rd, err);
      strap_pd <= ~pd;
      repeat (4) @(posedge pclk);
      apb(strap_pkg::STRAP_CONFIG_STATUS_OFFSET, 1'b0, 32'h0, rd, err);
      check("strap held", rd, strap_exp(pd));
      check("rom pads released", {24'h0, rom_addr_strap_oe_n}, 32'hFF);
      apb(strap_pkg::PAD_CONTROL_OFFSET, 1'b0, 32'h0, rd, err);
      check("pad control", rd, 32'h1);
    end
    apb(12'h4D0, 1'b0, 32'h0, rd, err);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(strap_pkg::PAD_CONTROL_OFFSET, 1'b1, 32'h0, rd, err);
    for (int i = 0; i < 4; i++) begin
      panel_data_core <= 4'($urandom);
      test_sel <= 4'($urandom);
      repeat (4) @(posedge pclk);
      check("panel oe_n", {28'h0, panel_data_oe_n}, 32'h0);
      check("panel out", {28'h0, panel_data_out}, {28'h0, panel_data_core});
      check("modes idle", {30'h0, connectivity_mode, all_outputs_hiz}, 32'h0);
    end
    test_on <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      test_sel <= 4'(c);
      repeat (5) @(posedge pclk);
      check("conn mode", {31'h0, connectivity_mode}, {31'h0, 4'(c) == 4'hE});
      check("hiz mode", {31'h0, all_outputs_hiz}, {31'h0, 4'(c) == 4'hF});
      if (c == 15) check("rom pads hiz", {24'h0, rom_addr_strap_oe_n}, 32'hFF);
      // Status shows the live mode; pin levels are the ROM drive, or the straps once floated
      if (c == 0 || c == 15) begin
        apb(strap_pkg::TEST_STATUS_OFFSET, 1'b0, 32'h0, rd, err);
        check("test status", rd, (c == 15) ? {16'h0, pd, 8'h0E} : {16'h0, rom_addr_core, 8'h07});
      end
    end
    test_sel <= 4'hE;
    for (int i = 0; i < 40; i++) begin
      v = (i < 32) ? ~(32'h1 << i) : (i == 32) ? 32'hFFFFFFFF : $urandom;
      iotest_drive <= v;
      repeat (4) @(posedge pclk);
      check("nand out", {24'h0, iotest_out}, {24'h0, nand_exp(v)});
      check("nand oe_n", {24'h0, iotest_oe_n}, 32'h0);
    end
    test_on <= 1'b0;
    repeat (4) @(posedge pclk);
    check("modes released", {30'h0, connectivity_mode, all_outputs_hiz}, 32'h0);
    check("iotest released", {24'h0, iotest_oe_n}, 32'hFF);
    check("panel back", {28'h0, panel_data_oe_n}, 32'h0);
    stop_test();
  end
endmodule : testbench
